//--- verilog/lcdl_pkg.sv
// Constants, register map and field layout for the loop carrier data link stack.
// Assumes one 100 MHz clock, a synchronous active-high reset and a Wishbone slave port.
package lcdl_pkg;

  localparam int LCDL_DW = 32;
  localparam int LCDL_AW = 8;

  localparam logic [7:0] LCDL_OFS_SRC_EN   = 8'h00;
  localparam logic [7:0] LCDL_OFS_SRC_SEL  = 8'h04;
  localparam logic [7:0] LCDL_OFS_STATUS   = 8'h08;
  localparam logic [7:0] LCDL_OFS_TX_STACK = 8'h10;
  localparam logic [7:0] LCDL_OFS_RX_STACK = 8'h30;
  localparam logic [5:0] LCDL_STACK_BYTES  = 6'h05;

  localparam int LCDL_SRC_EN_BIT    = 6;
  localparam int LCDL_SRC_SEL_LSB   = 5;
  localparam int LCDL_TX_RDY_BIT    = 5;
  localparam int LCDL_RX_RDY_BIT    = 4;
  localparam int LCDL_SYNC_LOST_BIT = 0;
  localparam logic [1:0] LCDL_SEL_STACK = 2'h2;

  localparam logic [3:0] LCDL_LAST_FRAME  = 4'hb;
  localparam logic [5:0] LCDL_LAST_SLOT   = 6'h23;
  localparam logic [5:0] LCDL_FIRST_DBIT  = 6'h0c;
  localparam logic [5:0] LCDL_LAST_FSBIT  = 6'h0b;
  localparam logic [4:0] LCDL_LAST_DBIT   = 5'h17;
  localparam logic [5:0] LCDL_FT_PATTERN  = 6'h2a;
  localparam logic [11:0] LCDL_FS_PATTERN = 12'h1c7;
  localparam logic [11:0] LCDL_HIST_RST   = 12'hfff;

  localparam logic [7:0] LCDL_FRAMING_BYTE = 8'h07;
  localparam logic [7:0] LCDL_TX_B2_RST    = 8'h00;
  localparam logic [7:0] LCDL_TX_B3_RST    = 8'h08;
  localparam logic [7:0] LCDL_TX_B4_RST    = 8'h1f;

  typedef enum logic {
    LCDL_RX_HUNT,
    LCDL_RX_COLLECT
  } lcdl_rx_state_t;

endpackage

//--- verilog/lcdl_fs_lock.sv
// Framing pattern finder for a serial signal-framing bit stream.
// Assumes bits arrive as one-cycle valid strobes at least two cycles apart.
`timescale 1ns/1ps
module lcdl_fs_lock (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic bit_valid_i,
  input  wire logic bit_i,
  output logic      hit_o
);
  import lcdl_pkg::*;

  typedef struct packed {
    logic [11:0] hist;
    logic        hit;
  } lcdl_lock_t;

  lcdl_lock_t q;
  lcdl_lock_t d;

  // History resets to all ones so that no false match can appear early.
  always_comb begin
    d = q;
    d.hit = 1'b0;
    if (bit_valid_i) begin
      d.hist = {q.hist[10:0], bit_i};
      d.hit  = ({q.hist[10:0], bit_i} == LCDL_FS_PATTERN);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q.hist <= LCDL_HIST_RST;
      q.hit  <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign hit_o = q.hit;

endmodule

//--- verilog/lcdl_stack.sv
// Superframe data link stack: transmit framing bit builder and receive word capture.
// Assumes frame strobes come from the surrounding framer at least two cycles apart.
//
// The address map and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
module lcdl_stack (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [lcdl_pkg::LCDL_AW-1:0] wb_adr_i,
  input  wire logic [lcdl_pkg::LCDL_DW-1:0] wb_dat_i,
  input  wire logic [3:0]                  wb_sel_i,
  output logic      [lcdl_pkg::LCDL_DW-1:0] wb_dat_o,
  output logic                             wb_ack_o,
  input  wire logic                        tx_frame_i,
  input  wire logic                        ext_link_i,
  output logic                             ext_link_req_o,
  output logic                             tx_fbit_o,
  output logic                             tx_sf_start_o,
  input  wire logic                        rx_frame_i,
  input  wire logic                        rx_fs_slot_i,
  input  wire logic                        rx_fbit_i,
  input  wire logic                        rx_sf_aligned_i,
  output logic                             rx_link_o,
  output logic                             rx_link_valid_o
);
  import lcdl_pkg::*;

  typedef struct packed {
    logic             ack;
    logic [31:0]      rdat;
    logic             src_en;
    logic [2:0]       src_sel;
    logic [4:0][7:0]  tx_stk;
    logic [23:0]      tx_shadow;
    logic [4:0][7:0]  rx_stk;
    logic             tx_rdy;
    logic             rx_rdy;
    logic [3:0]       tx_frame;
    logic [5:0]       tx_slot;
    logic             tx_fbit;
    logic             tx_sf_start;
    logic             ext_req;
    lcdl_rx_state_t   rx_st;
    logic [4:0]       rx_cnt;
    logic [23:0]      rx_word;
    logic             rx_link;
    logic             rx_link_valid;
  } lcdl_state_t;

  lcdl_state_t q;
  lcdl_state_t d;

  logic tx_lock;
  logic rx_lock;
  logic stk_mode;
  logic tx_fs_frame;

  // Returns {hit, index} for an aligned word inside a five-byte stack window.
  function automatic logic [3:0] stack_hit(input logic [7:0] adr,
                                           input logic [7:0] base);
    logic [7:0] off;
    off = adr - base;
    stack_hit = {(off[1:0] == 2'h0) && (off[7:2] < LCDL_STACK_BYTES), off[4:2]};
  endfunction

  // The 36-bit signal framing sequence: two framing fields, then the word.
  function automatic logic [35:0] fs_vector(input logic [7:0] b0,
                                            input logic [7:0] b1,
                                            input logic [23:0] word);
    fs_vector = {b0[5:0], b1[5:0], word};
  endfunction

  assign stk_mode = q.src_en && (q.src_sel[1:0] == LCDL_SEL_STACK);
  assign tx_fs_frame = q.tx_frame[0];

  lcdl_fs_lock u_tx_lock (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .bit_valid_i (tx_frame_i && tx_fs_frame && !stk_mode),
    .bit_i       (ext_link_i),
    .hit_o       (tx_lock)
  );

  lcdl_fs_lock u_rx_lock (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .bit_valid_i (rx_frame_i && rx_fs_slot_i),
    .bit_i       (rx_fbit_i),
    .hit_o       (rx_lock)
  );

  always_comb begin
    logic        req;
    logic [3:0]  txh;
    logic [3:0]  rxh;
    logic [35:0] vec;
    logic [23:0] word;
    req  = wb_cyc_i && wb_stb_i && !q.ack;
    txh  = stack_hit(wb_adr_i, LCDL_OFS_TX_STACK);
    rxh  = stack_hit(wb_adr_i, LCDL_OFS_RX_STACK);
    vec  = fs_vector(q.tx_stk[0], q.tx_stk[1], q.tx_shadow);
    word = {q.rx_word[22:0], rx_fbit_i};
    d = q;
    d.ack           = 1'b0;
    d.tx_sf_start   = 1'b0;
    d.ext_req       = 1'b0;
    d.rx_link_valid = 1'b0;

    // Register access answers one cycle after the request; unmapped reads give zero.
    if (req) begin
      d.ack  = 1'b1;
      d.rdat = '0;
      if (wb_we_i && wb_sel_i[0]) begin
        if (wb_adr_i == LCDL_OFS_SRC_EN) begin
          d.src_en = wb_dat_i[LCDL_SRC_EN_BIT];
        end else if (wb_adr_i == LCDL_OFS_SRC_SEL) begin
          d.src_sel = wb_dat_i[LCDL_SRC_SEL_LSB +: 3];
        end else if (txh[3]) begin
          d.tx_stk[txh[2:0]] = wb_dat_i[7:0];
        end
      end else if (!wb_we_i) begin
        if (wb_adr_i == LCDL_OFS_SRC_EN) begin
          d.rdat[LCDL_SRC_EN_BIT] = q.src_en;
        end else if (wb_adr_i == LCDL_OFS_SRC_SEL) begin
          d.rdat[LCDL_SRC_SEL_LSB +: 3] = q.src_sel;
        end else if (wb_adr_i == LCDL_OFS_STATUS) begin
          d.rdat[LCDL_TX_RDY_BIT]    = q.tx_rdy;
          d.rdat[LCDL_RX_RDY_BIT]    = q.rx_rdy;
          d.rdat[LCDL_SYNC_LOST_BIT] = !rx_sf_aligned_i;
          // Clearing here comes before the sets below, so a new event wins.
          d.tx_rdy = 1'b0;
          d.rx_rdy = 1'b0;
        end else if (txh[3]) begin
          d.rdat[7:0] = q.tx_stk[txh[2:0]];
        end else if (rxh[3]) begin
          d.rdat[7:0] = q.rx_stk[rxh[2:0]];
        end
      end
    end

    // Transmit side: even frames carry the terminal pattern, odd ones the sequence.
    if (tx_frame_i) begin
      d.tx_sf_start = (q.tx_frame == 4'h0);
      if (q.tx_frame == LCDL_LAST_FRAME) begin
        d.tx_frame = 4'h0;
      end else begin
        d.tx_frame = q.tx_frame + 4'h1;
      end
      if (!tx_fs_frame) begin
        d.tx_fbit = LCDL_FT_PATTERN[3'h5 - q.tx_frame[3:1]];
      end else begin
        if (stk_mode) begin
          // Spoiler bits pass straight from the stack with no forcing.
          d.tx_fbit = vec[6'h23 - q.tx_slot];
        end else begin
          d.tx_fbit  = ext_link_i;
          d.ext_req  = 1'b1;
        end
        if (q.tx_slot == LCDL_LAST_SLOT) begin
          d.tx_slot = 6'h00;
        end else begin
          d.tx_slot = q.tx_slot + 6'h01;
        end
        // The word is frozen at the start of its interval; the stack is then free
        // for about 9 ms, and an untouched stack simply goes out again.
        if (q.tx_slot == LCDL_LAST_FSBIT && stk_mode) begin
          d.tx_shadow = {q.tx_stk[2], q.tx_stk[3], q.tx_stk[4]};
          d.tx_rdy    = 1'b1;
        end
      end
    end
    // A found pattern on the external stream forces the next bit to be the first word bit.
    if (tx_lock && !stk_mode) begin
      d.tx_slot = LCDL_FIRST_DBIT;
    end

    // Receive side: the word follows a framing pattern match.
    if (rx_frame_i && rx_fs_slot_i) begin
      d.rx_link       = rx_fbit_i;
      d.rx_link_valid = 1'b1;
      case (q.rx_st)
        LCDL_RX_HUNT: begin
          d.rx_cnt = 5'h00;
        end
        LCDL_RX_COLLECT: begin
          d.rx_word = word;
          d.rx_cnt  = q.rx_cnt + 5'h01;
          if (q.rx_cnt == LCDL_LAST_DBIT) begin
            d.rx_st = LCDL_RX_HUNT;
            if (rx_sf_aligned_i && stk_mode) begin
              d.rx_stk[0] = LCDL_FRAMING_BYTE;
              d.rx_stk[1] = LCDL_FRAMING_BYTE;
              d.rx_stk[2] = word[23:16];
              d.rx_stk[3] = word[15:8];
              d.rx_stk[4] = word[7:0];
              d.rx_rdy    = 1'b1;
            end
          end
        end
        default: begin
          d.rx_st = LCDL_RX_HUNT;
        end
      endcase
    end
    if (rx_lock) begin
      d.rx_st  = LCDL_RX_COLLECT;
      d.rx_cnt = 5'h00;
    end
    // Loss of superframe alignment abandons the word in progress.
    if (!rx_sf_aligned_i) begin
      d.rx_st = LCDL_RX_HUNT;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q.ack           <= 1'b0;
      q.rdat          <= '0;
      q.src_en        <= 1'b0;
      q.src_sel       <= 3'h0;
      q.tx_stk[0]     <= LCDL_FRAMING_BYTE;
      q.tx_stk[1]     <= LCDL_FRAMING_BYTE;
      q.tx_stk[2]     <= LCDL_TX_B2_RST;
      q.tx_stk[3]     <= LCDL_TX_B3_RST;
      q.tx_stk[4]     <= LCDL_TX_B4_RST;
      q.tx_shadow     <= {LCDL_TX_B2_RST, LCDL_TX_B3_RST, LCDL_TX_B4_RST};
      q.rx_stk        <= '0;
      q.tx_rdy        <= 1'b0;
      q.rx_rdy        <= 1'b0;
      q.tx_frame      <= 4'h0;
      q.tx_slot       <= 6'h00;
      q.tx_fbit       <= 1'b0;
      q.tx_sf_start   <= 1'b0;
      q.ext_req       <= 1'b0;
      q.rx_st         <= LCDL_RX_HUNT;
      q.rx_cnt        <= 5'h00;
      q.rx_word       <= 24'h000000;
      q.rx_link       <= 1'b0;
      q.rx_link_valid <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign wb_dat_o        = q.rdat;
  assign wb_ack_o        = q.ack;
  assign ext_link_req_o  = q.ext_req;
  assign tx_fbit_o       = q.tx_fbit;
  assign tx_sf_start_o   = q.tx_sf_start;
  assign rx_link_o       = q.rx_link;
  assign rx_link_valid_o = q.rx_link_valid;

endmodule

//--- verif/lcdl_far_end.sv
// Far-end model: remote terminal giving frame strobes and framing bits.
// Assumes the block's clock and a synchronous active-high reset.
`timescale 1ns/1ps
module lcdl_far_end (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [23:0] word_i,
  output logic             frame_o,
  output logic             fs_slot_o,
  output logic             fbit_o
);
  logic [1:0]  ph_q;
  logic [3:0]  fr_q;
  logic [5:0]  sl_q;
  logic [35:0] seq_w;
  assign seq_w = {12'h1c7, word_i};
  // A strobe every fourth cycle keeps the spacing the block needs.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ph_q <= 2'h0;
      fr_q <= 4'h0;
      // Starting off the block's own slot count forces the block to find the pattern.
      sl_q <= 6'h05;
    end else begin
      ph_q <= ph_q + 2'h1;
      if (frame_o) begin
        fr_q <= (fr_q == 4'hb) ? 4'h0 : fr_q + 4'h1;
        if (fr_q[0]) sl_q <= (sl_q == 6'h23) ? 6'h00 : sl_q + 6'h01;
      end
    end
  end
  assign frame_o   = (ph_q == 2'h3);
  assign fs_slot_o = frame_o & fr_q[0];
  assign fbit_o    = fr_q[0] ? seq_w[6'h23 - sl_q] : ~fr_q[1];
endmodule

//--- verif/lcdl_stack_checker.sv
// Port checker for the data link stack.
// Assumes it is bound to lcdl_stack and sees its ports only.
`timescale 1ns/1ps
module lcdl_stack_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic tx_frame_i,
  input wire logic ext_link_i,
  input wire logic tx_fbit_o,
  input wire logic tx_sf_start_o,
  input wire logic ext_link_req_o,
  input wire logic rx_frame_i,
  input wire logic rx_fs_slot_i,
  input wire logic rx_fbit_i,
  input wire logic rx_link_o,
  input wire logic rx_link_valid_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_rx; rx_frame_i && rx_fs_slot_i; endsequence
  property p_ack_time; s_req |=> wb_ack_o; endproperty
  a_ack_time: assert property (p_ack_time) else $error("ack late");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_ack_cause; wb_ack_o |-> $past(wb_stb_i); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_sf_bit; tx_sf_start_o |-> tx_fbit_o && $past(tx_frame_i); endproperty
  a_sf_bit: assert property (p_sf_bit) else $error("bad superframe start");
  property p_hold; !$past(tx_frame_i) |-> $stable(tx_fbit_o); endproperty
  a_hold: assert property (p_hold) else $error("framing bit moved");
  property p_rx_echo; s_rx |=> rx_link_valid_o && rx_link_o == $past(rx_fbit_i); endproperty
  a_rx_echo: assert property (p_rx_echo) else $error("rx bit lost");
  property p_rx_cause; rx_link_valid_o |-> $past(rx_fs_slot_i) && $past(rx_frame_i); endproperty
  a_rx_cause: assert property (p_rx_cause) else $error("rx valid unasked");
  property p_ext_req; ext_link_req_o |-> $past(tx_frame_i); endproperty
  a_ext_req: assert property (p_ext_req) else $error("ext request unasked");
  property p_ext_bit; ext_link_req_o |-> tx_fbit_o == $past(ext_link_i); endproperty
  a_ext_bit: assert property (p_ext_bit) else $error("ext bit not passed");
endmodule
bind lcdl_stack lcdl_stack_checker u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .tx_frame_i, .ext_link_i, .tx_fbit_o, .tx_sf_start_o, .ext_link_req_o, .rx_frame_i,
  .rx_fs_slot_i,
  .rx_fbit_i, .rx_link_o, .rx_link_valid_o);

//--- verif/loop_carrier_datalink_stack_tb.sv
// Self-checking bench for the data link stack with a far-end model.
// Assumes a 100 MHz clock and the register map of lcdl_pkg.
`timescale 1ns/1ps
module loop_carrier_datalink_stack_tb;
  import lcdl_pkg::*;
  logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdat;
  logic [3:0]  wb_sel_i = 4'hf;
  logic        rx_sf_aligned_i = 1'b1, fs_d = 1'b0;
  logic [23:0] word = 24'h9e4b5b;
  logic        wb_ack_o, tx_frame_i, fs, fbit, ext_link_req_o, tx_fbit_o, tx_sf_start_o;
  logic        rx_link_o, rx_link_valid_o;
  logic [35:0] hist = 36'h0;
  logic [7:0]  rx_exp [5] = '{8'h07, 8'h07, 8'h9e, 8'h4b, 8'h5b};
  int          n_mismatch = 0, samples_checked = 0;
  initial forever #5 clk_i = ~clk_i;
  lcdl_far_end far (.clk_i, .rst_i, .word_i(word), .frame_o(tx_frame_i), .fs_slot_o(fs),
    .fbit_o(fbit));
  lcdl_stack dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i,
    .wb_sel_i, .wb_dat_o, .wb_ack_o, .tx_frame_i, .ext_link_i(fbit), .ext_link_req_o,
    .tx_fbit_o, .tx_sf_start_o, .rx_frame_i(tx_frame_i), .rx_fs_slot_i(fs),
    .rx_fbit_i(fbit), .rx_sf_aligned_i, .rx_link_o, .rx_link_valid_o);
  // Newest transmitted signal-framing bit lands in bit 0.
  always @(posedge clk_i) begin
    fs_d <= fs;
    if (fs_d) hist <= {hist[34:0], tx_fbit_o};
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    chk("ack", 36'h1, {35'h0, wb_ack_o});
    if (wb_ack_o !== 1'b1) final_report;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, {4'h0, e}, {4'h0, rdat});
  endtask
  task automatic wait_status(input int b);
    int n;
    n = 0;
    do begin
      bus(1'b0, LCDL_OFS_STATUS, 32'h0);
      n++;
    end while (rdat[b] !== 1'b1 && n < 300);
    chk("ready", 36'h1, {35'h0, rdat[b]});
    if (rdat[b] !== 1'b1) final_report;
  endtask
  task automatic wait_hist(input logic [35:0] e, input string nm);
    int n;
    n = 0;
    while (hist !== e && n < 800) begin
      @(posedge clk_i);
      n++;
    end
    chk(nm, e, hist);
    if (hist !== e) final_report;
  endtask
  task automatic t_reset;
    rd_chk(LCDL_OFS_STATUS, 32'h0, "status");
    rd_chk(8'hfc, 32'h0, "unmapped");
    rd_chk(LCDL_OFS_TX_STACK, 32'h07, "tx_byte1");
  endtask
  // Spoilers stored inverted show that none is forced on the way out.
  task automatic t_tx_stack;
    bus(1'b1, LCDL_OFS_TX_STACK, 32'h07);
    bus(1'b1, LCDL_OFS_TX_STACK + 8'h04, 32'h07);
    bus(1'b1, LCDL_OFS_TX_STACK + 8'h08, 32'hc3);
    bus(1'b1, LCDL_OFS_TX_STACK + 8'h0c, 32'hd6);
    bus(1'b1, LCDL_OFS_TX_STACK + 8'h10, 32'hb4);
    bus(1'b1, LCDL_OFS_SRC_EN, 32'h40);
    bus(1'b1, LCDL_OFS_SRC_SEL, 32'h40);
    wait_status(LCDL_TX_RDY_BIT);
    wait_hist({12'h1c7, 24'hc3d6b4}, "tx_word");
    repeat (16) @(posedge clk_i);
    wait_hist({12'h1c7, 24'hc3d6b4}, "tx_resend");
    wait_status(LCDL_TX_RDY_BIT);
    bus(1'b0, LCDL_OFS_STATUS, 32'h0);
    chk("tx_ready", 36'h0, {35'h0, rdat[LCDL_TX_RDY_BIT]});
    bus(1'b1, LCDL_OFS_TX_STACK + 8'h08, 32'h3c);
    wait_hist({12'h1c7, 24'h3cd6b4}, "tx_update");
  endtask
  task automatic t_rx;
    wait_status(LCDL_RX_RDY_BIT);
    for (int i = 0; i < 5; i++) begin
      rd_chk(LCDL_OFS_RX_STACK + 8'(4 * i), {24'h0, rx_exp[i]}, "rx_byte");
    end
    bus(1'b0, LCDL_OFS_STATUS, 32'h0);
    chk("rx_ready", 36'h0, {35'h0, rdat[LCDL_RX_RDY_BIT]});
  endtask
  task automatic t_lost;
    rx_sf_aligned_i <= 1'b0;
    word <= 24'h0;
    bus(1'b0, LCDL_OFS_STATUS, 32'h0);
    chk("sync_lost", 36'h1, {35'h0, rdat[LCDL_SYNC_LOST_BIT]});
    repeat (700) @(posedge clk_i);
    bus(1'b0, LCDL_OFS_STATUS, 32'h0);
    chk("rx_ready", 36'h0, {35'h0, rdat[LCDL_RX_RDY_BIT]});
    rd_chk(LCDL_OFS_RX_STACK + 8'h08, 32'h9e, "rx_hold");
    rx_sf_aligned_i <= 1'b1;
    word <= 24'h9e4b5b;
  endtask
  task automatic t_ext;
    bus(1'b1, LCDL_OFS_SRC_SEL, 32'h0);
    wait_hist({12'h1c7, 24'h9e4b5b}, "ext_word");
    bus(1'b0, LCDL_OFS_STATUS, 32'h0);
    repeat (300) @(posedge clk_i);
    bus(1'b0, LCDL_OFS_STATUS, 32'h0);
    chk("tx_ready", 36'h0, {35'h0, rdat[LCDL_TX_RDY_BIT]});
    chk("sync_lost", 36'h0, {35'h0, rdat[LCDL_SYNC_LOST_BIT]});
    // Back on the stack, the word must end where the far end ends its own sequence.
    bus(1'b1, LCDL_OFS_SRC_SEL, 32'h40);
    wait_hist({12'h1c7, 24'h3cd6b4}, "relock_word");
    chk("tx_align", 36'h0, {30'h0, far.sl_q});
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_tx_stack;
    t_rx;
    t_lost;
    t_ext;
    final_report;
  end
endmodule
